// >>> hcm_bus_peer.sv
// Backplane peer model: drives the A and B group frame signals.
// Assumes the bench link clock; frames one link cycle wide, B half a period after A.
`timescale 1ns/100ps
module hcm_bus_peer #(
    parameter int PERIOD = hcm_pkg::FRAME_LINK_CYCLES,
    parameter int B_OFS  = 512
) (
    // Link
    input  wire logic link_clk_i,
    input  wire logic rst_i,
    // Frames
    output logic      a_frame_o,
    output logic      b_frame_o
);
    int cnt;
    always_ff @(posedge link_clk_i) begin
        if (rst_i) begin
            cnt <= 0;
        end else begin
            cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
        end
        a_frame_o <= !rst_i && cnt == 0;
        b_frame_o <= !rst_i && cnt == B_OFS;
    end
endmodule

// >>> hcm_clock_mode.sv
// H.110 clock role, reference select, failure source and frame alignment.
// Assumes classic Wishbone on clk_i and backplane frame signals timed by link_clk_i.
//
// Functional notes
// - Primary master drives A group, monitors B
// - Secondary master drives B, primary from A clock
// - Slave drives neither; both frequency codes are bus
// - Preferred reference always the primary one
// - Frequency codes 8k, 1.544M, 2.048M, bus clock
// - Secondary source encoding; bus code selects B clock
// - Primary source same encoding; bus code selects A
// - Align frames to A frame when primary active on bus clock
// - Align frames to B frame when secondary active on bus clock
// - Correction reset bit holds circuit; slave forces it
// - Primary master automatic detect; others auto or external
// - External mode takes failure from loss inputs
// - Phase offset two's complement, 15 or 20 ns
// - Skew delays outputs 0 to 7 steps of 3.5 ns
`timescale 1ns/100ps
module hcm_clock_mode #(
    parameter int ADR_W = 8
) (
    // System
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    // Wishbone slave
    input  wire logic                cyc_i,
    input  wire logic                stb_i,
    input  wire logic                we_i,
    input  wire logic [ADR_W-1:0]    adr_i,
    input  wire logic [3:0]          sel_i,
    input  wire logic [31:0]         dat_i,
    output logic      [31:0]         dat_o,
    output logic                     ack_o,
    // DPLL side, same clock
    input  wire logic                dpll_on_secondary_i,
    input  wire logic                monitor_pri_fail_i,
    input  wire logic                monitor_sec_fail_i,
    // Loss pins, asynchronous
    input  wire logic                primary_loss_input_i,
    input  wire logic                secondary_loss_input_i,
    // Clocking configuration to the DPLL
    output hcm_pkg::hcm_role_t       role_o,
    output logic                     a_group_oe_o,
    output logic                     b_group_oe_o,
    output logic                     prefer_secondary_o,
    output logic      [1:0]          primary_freq_o,
    output logic      [1:0]          secondary_freq_o,
    output hcm_pkg::hcm_src_t        primary_ref_o,
    output hcm_pkg::hcm_src_t        secondary_ref_o,
    output logic                     tie_reset_o,
    output logic                     external_detect_o,
    output logic                     primary_fail_o,
    output logic                     secondary_fail_o,
    output logic signed [23:0]       phase_offset_ps_o,
    output logic      [15:0]         output_skew_ps_o,
    // Link side
    input  wire logic                link_clk_i,
    input  wire logic                a_group_frame_i,
    input  wire logic                b_group_frame_i,
    output logic                     frame_o
);

    // Address decode needs at least the eight low byte address bits
    if (ADR_W < 8) begin : g_bad_adr_w
        $error("ADR_W must be at least 8");
    end

    localparam int FRAME_CNT_W = $clog2(hcm_pkg::FRAME_LINK_CYCLES);

    // Source field decode shared by both references
    function automatic hcm_pkg::hcm_src_t decode_src(input logic [1:0] freq,
                                                     input logic [3:0] sel);
        hcm_pkg::hcm_src_t r;
        r = hcm_pkg::SRC_NONE;
        if (freq == hcm_pkg::FREQ_BUS_8M) begin
            r = hcm_pkg::SRC_BUS_CLOCK;
        end else begin
            case (sel)
                4'h0:    r = hcm_pkg::SRC_BUS_REF_1;
                4'h1:    r = hcm_pkg::SRC_BUS_REF_2;
                4'h8:    r = hcm_pkg::SRC_LOCAL_0;
                4'h9:    r = hcm_pkg::SRC_LOCAL_1;
                4'hA:    r = hcm_pkg::SRC_LOCAL_2;
                4'hB:    r = hcm_pkg::SRC_LOCAL_3;
                default: r = hcm_pkg::SRC_NONE;
            endcase
        end
        return r;
    endfunction

    // Byte-lane merge for a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [31:0] wr,
                                            input logic [3:0]  sel);
        logic [15:0] r;
        r = old_v;
        if (sel[0]) r[7:0] = wr[7:0];
        if (sel[1]) r[15:8] = wr[15:8];
        return r;
    endfunction

    // Registers
    hcm_pkg::hcm_mode_one_t mode_one;
    hcm_pkg::hcm_mode_two_t mode_two;
    hcm_pkg::hcm_out_adj_t  out_adj;

    // Bus decode
    wire logic [5:0] word_idx = adr_i[7:2];
    wire logic       bus_req  = cyc_i & stb_i & ~ack_o;
    wire logic       wr_req   = bus_req & we_i;
    wire logic       hit_one  = word_idx == hcm_pkg::IDX_MODE_ONE;
    wire logic       hit_two  = word_idx == hcm_pkg::IDX_MODE_TWO;
    wire logic       hit_adj  = word_idx == hcm_pkg::IDX_OUT_ADJ;
    wire logic       hit_stat = word_idx == hcm_pkg::IDX_STATUS;
    wire logic       upper_zero;

    generate
        if (ADR_W > 8) begin : g_hi
            assign upper_zero = ~|adr_i[ADR_W-1:8];
        end else begin : g_nohi
            assign upper_zero = 1'b1;
        end
    endgenerate

    // Role decode from the two drive bits
    wire logic drv_a = mode_one.drive_a_group;
    wire logic drv_b = mode_one.drive_b_group;
    wire hcm_pkg::hcm_role_t role =
        (drv_a & ~drv_b) ? hcm_pkg::ROLE_PRIMARY :
        (drv_b & ~drv_a) ? hcm_pkg::ROLE_SECONDARY :
        (~drv_a & ~drv_b) ? hcm_pkg::ROLE_SLAVE : hcm_pkg::ROLE_INVALID;
    wire logic is_pm  = role == hcm_pkg::ROLE_PRIMARY;
    wire logic is_sm  = role == hcm_pkg::ROLE_SECONDARY;
    wire logic is_slv = role == hcm_pkg::ROLE_SLAVE;

    // Effective frequency codes
    wire logic [1:0] eff_pri_freq = (is_sm | is_slv) ? hcm_pkg::FREQ_BUS_8M
                                                      : mode_one.primary_freq_code;
    wire logic [1:0] eff_sec_freq = is_slv ? hcm_pkg::FREQ_BUS_8M
                                           : mode_one.secondary_freq_code;

    // Reference sources; bus code overrides the source field
    wire hcm_pkg::hcm_src_t eff_pri_src = decode_src(eff_pri_freq,
                                                     mode_one.primary_source_sel);
    wire hcm_pkg::hcm_src_t eff_sec_src = decode_src(eff_sec_freq,
                                                     mode_one.secondary_source_sel);

    // Correction reset and failure detect mode
    wire logic       eff_tie_rst = is_slv | mode_two.tie_correction_reset;
    wire logic [1:0] fdm_req     = mode_two.failure_detect_mode;
    wire logic       eff_ext     = ~is_pm & (fdm_req == hcm_pkg::FDM_EXTERNAL);

    // Misprogramming flag
    wire logic cfg_error = mode_one.preferred_ref_select
        | (role == hcm_pkg::ROLE_INVALID)
        | (is_pm & (fdm_req != hcm_pkg::FDM_AUTO))
        | (~is_pm & fdm_req[1])
        | (is_slv & ~mode_two.tie_correction_reset)
        | ((is_sm | is_slv) & (mode_one.primary_freq_code != hcm_pkg::FREQ_BUS_8M))
        | (is_slv & (mode_one.secondary_freq_code != hcm_pkg::FREQ_BUS_8M));

    // Loss pins pass two flip-flops
    logic [1:0] loss_meta;
    logic [1:0] loss_sync;

    always_ff @(posedge clk_i) begin
        loss_meta <= {secondary_loss_input_i, primary_loss_input_i};
        loss_sync <= loss_meta;
    end

    // Failure source select
    wire logic pri_fail = eff_ext ? loss_sync[0] : monitor_pri_fail_i;
    wire logic sec_fail = eff_ext ? loss_sync[1] : monitor_sec_fail_i;

    // Phase step follows the frequency of the active reference
    wire logic [1:0] act_freq = dpll_on_secondary_i ? eff_sec_freq : eff_pri_freq;
    wire logic signed [23:0] step_ps = (act_freq == hcm_pkg::FREQ_1544K)
        ? 24'(hcm_pkg::PHASE_STEP_COARSE_PS) : 24'(hcm_pkg::PHASE_STEP_FINE_PS);
    wire logic signed [23:0] offs_ext = 24'(signed'(out_adj.phase_offset));
    wire logic signed [23:0] phase_ps = 24'(offs_ext * step_ps);
    wire logic [15:0] skew_ps = 16'(out_adj.output_skew * hcm_pkg::SKEW_STEP_PS);

    // Frame alignment choice
    wire logic align_a = (eff_pri_src == hcm_pkg::SRC_BUS_CLOCK) & ~dpll_on_secondary_i;
    wire logic align_b = (eff_sec_src == hcm_pkg::SRC_BUS_CLOCK) & dpll_on_secondary_i;

    // Lock indication returned from the link side
    logic       link_locked;
    logic [1:0] lock_meta;
    logic [1:0] lock_sync;

    always_ff @(posedge clk_i) begin
        lock_meta <= {lock_meta[0], link_locked};
        lock_sync <= {lock_sync[0], lock_meta[1]};
    end

    // Read mux
    wire logic [15:0] status_word = {9'h000, lock_sync[1], eff_ext, sec_fail, pri_fail,
                                     cfg_error, role};
    wire logic [15:0] rd_word =
        ~upper_zero ? 16'h0000 :
        hit_one     ? mode_one :
        hit_two     ? mode_two :
        hit_adj     ? (out_adj & hcm_pkg::OUT_ADJ_MASK) :
        hit_stat    ? status_word : 16'h0000;

    // Register writes and bus answer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_one <= hcm_pkg::RST_MODE_ONE;
            mode_two <= hcm_pkg::RST_MODE_TWO;
            out_adj  <= hcm_pkg::RST_OUT_ADJ;
            ack_o    <= 1'b0;
            dat_o    <= 32'h0000_0000;
        end else begin
            ack_o <= bus_req;
            if (bus_req) begin
                dat_o <= we_i ? 32'h0000_0000 : {16'h0000, rd_word};
            end
            if (wr_req & upper_zero & hit_one) begin
                mode_one <= merge16(mode_one, dat_i, sel_i);
            end
            if (wr_req & upper_zero & hit_two) begin
                mode_two <= merge16(mode_two, dat_i, sel_i);
            end
            if (wr_req & upper_zero & hit_adj) begin
                out_adj <= merge16(out_adj, dat_i, sel_i) & hcm_pkg::OUT_ADJ_MASK;
            end
        end
    end

    // Registered configuration outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            role_o             <= hcm_pkg::ROLE_SLAVE;
            a_group_oe_o       <= 1'b0;
            b_group_oe_o       <= 1'b0;
            prefer_secondary_o <= 1'b0;
            primary_freq_o     <= hcm_pkg::FREQ_8K;
            secondary_freq_o   <= hcm_pkg::FREQ_8K;
            primary_ref_o      <= hcm_pkg::SRC_NONE;
            secondary_ref_o    <= hcm_pkg::SRC_NONE;
            tie_reset_o        <= 1'b1;
            external_detect_o  <= 1'b0;
            primary_fail_o     <= 1'b0;
            secondary_fail_o   <= 1'b0;
            phase_offset_ps_o  <= 24'sh000000;
            output_skew_ps_o   <= 16'h0000;
        end else begin
            role_o             <= role;
            a_group_oe_o       <= is_pm;
            b_group_oe_o       <= is_sm;
            prefer_secondary_o <= 1'b0;
            primary_freq_o     <= eff_pri_freq;
            secondary_freq_o   <= eff_sec_freq;
            primary_ref_o      <= eff_pri_src;
            secondary_ref_o    <= eff_sec_src;
            tie_reset_o        <= eff_tie_rst;
            external_detect_o  <= eff_ext;
            primary_fail_o     <= pri_fail;
            secondary_fail_o   <= sec_fail;
            phase_offset_ps_o  <= phase_ps;
            output_skew_ps_o   <= skew_ps;
        end
    end

    // Link domain: reset and alignment choice cross by two flip-flops
    logic [1:0] lrst_sync;
    logic [1:0] align_meta;
    logic [1:0] align_sync;

    always_ff @(posedge link_clk_i) begin
        lrst_sync  <= {lrst_sync[0], rst_i};
        align_meta <= {align_b, align_a};
        align_sync <= align_meta;
    end

    wire logic link_rst = lrst_sync[1];

    // Frame pins pass two flip-flops, then the edge detect on the link clock
    logic [1:0] frame_q;
    logic [1:0] frame_qq;
    logic [1:0] frame_q3;
    logic [FRAME_CNT_W-1:0] frame_cnt;

    wire logic rise_a    = frame_qq[0] & ~frame_q3[0];
    wire logic rise_b    = frame_qq[1] & ~frame_q3[1];
    wire logic ext_frame = (align_sync[0] & rise_a) | (align_sync[1] & rise_b);
    wire logic cnt_wrap  = frame_cnt == FRAME_CNT_W'(hcm_pkg::FRAME_LINK_CYCLES - 1);
    wire logic aligned   = |align_sync;

    always_ff @(posedge link_clk_i) begin
        if (link_rst) begin
            frame_q     <= 2'h0;
            frame_qq    <= 2'h0;
            frame_q3    <= 2'h0;
            frame_cnt   <= '0;
            frame_o     <= 1'b0;
            link_locked <= 1'b0;
        end else begin
            frame_q  <= {b_group_frame_i, a_group_frame_i};
            frame_qq <= frame_q;
            frame_q3 <= frame_qq;
            if (ext_frame | cnt_wrap) begin
                frame_cnt <= '0;
            end else begin
                frame_cnt <= frame_cnt + 1'b1;
            end
            frame_o <= aligned ? ext_frame : cnt_wrap;
            if (~aligned) begin
                link_locked <= 1'b0;
            end else if (ext_frame) begin
                link_locked <= 1'b1;
            end
        end
    end

endmodule

// >>> hcm_clock_mode_props.sv
// Concurrent checks on the ports of the clock mode block.
// Assumes binding into hcm_clock_mode; all checks run on clk_i.
`timescale 1ns/100ps
module hcm_clock_mode_props (
    // System
    input wire logic                clk_i,
    input wire logic                rst_i,
    // Register port
    input wire logic                cyc_i,
    input wire logic                stb_i,
    input wire logic [31:0]         dat_o,
    input wire logic                ack_o,
    // Configuration
    input wire hcm_pkg::hcm_role_t  role_o,
    input wire logic                a_group_oe_o,
    input wire logic                b_group_oe_o,
    input wire logic                prefer_secondary_o,
    input wire logic [1:0]          primary_freq_o,
    input wire logic [1:0]          secondary_freq_o,
    input wire hcm_pkg::hcm_src_t   primary_ref_o,
    input wire hcm_pkg::hcm_src_t   secondary_ref_o,
    input wire logic                tie_reset_o,
    input wire logic                external_detect_o,
    input wire logic                primary_fail_o,
    input wire logic                primary_loss_input_i,
    input wire logic [15:0]         output_skew_ps_o
);
    logic [1:0] rdy;
    always_ff @(posedge clk_i) begin
        rdy <= {rdy[0], ~rst_i};
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i || !rdy[1]);
    chk_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
    chk_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i) && dat_o[31:16] == 16'h0000)
        else $error("ack without request or upper data set");
    chk_primary_drive: assert property (role_o == hcm_pkg::ROLE_PRIMARY |->
        a_group_oe_o && !b_group_oe_o) else $error("primary role drive wrong");
    chk_secondary_drive: assert property (role_o == hcm_pkg::ROLE_SECONDARY |->
        b_group_oe_o && !a_group_oe_o && primary_freq_o == hcm_pkg::FREQ_BUS_8M)
        else $error("secondary role drive wrong");
    chk_slave_monitor: assert property (role_o == hcm_pkg::ROLE_SLAVE |-> !a_group_oe_o &&
        !b_group_oe_o && primary_freq_o == 2'h3 && secondary_freq_o == 2'h3)
        else $error("slave role config wrong");
    chk_pref_primary: assert property (!prefer_secondary_o) else $error("secondary preferred");
    chk_bus_src_sec: assert property (secondary_freq_o == hcm_pkg::FREQ_BUS_8M |->
        secondary_ref_o == hcm_pkg::SRC_BUS_CLOCK) else $error("secondary not bus clock");
    chk_bus_src_pri: assert property (primary_freq_o == hcm_pkg::FREQ_BUS_8M |->
        primary_ref_o == hcm_pkg::SRC_BUS_CLOCK) else $error("primary not bus clock");
    chk_slave_tie: assert property (role_o == hcm_pkg::ROLE_SLAVE |-> tie_reset_o)
        else $error("correction runs in slave");
    chk_auto_primary: assert property (role_o == hcm_pkg::ROLE_PRIMARY |-> !external_detect_o)
        else $error("external detect in primary role");
    chk_loss_follow: assert property ((external_detect_o &&
        $stable(primary_loss_input_i))[*4] |-> primary_fail_o == primary_loss_input_i)
        else $error("failure not from loss pin");
    chk_skew_steps: assert property (output_skew_ps_o % 16'h0DAC == 16'h0000 &&
        output_skew_ps_o <= 16'h5FB4) else $error("skew off step grid");
endmodule

// >>> hcm_pkg.sv
// Package for the H.110 clock mode and reference select block.
// Assumes a 32-bit classic Wishbone register port and a 8.192 MHz link clock.
package hcm_pkg;

    // Register word indices; byte address is four times the index
    localparam logic [5:0] IDX_MODE_ONE  = 6'h2B;
    localparam logic [5:0] IDX_MODE_TWO  = 6'h2C;
    localparam logic [5:0] IDX_OUT_ADJ   = 6'h2D;
    localparam logic [5:0] IDX_STATUS    = 6'h30;

    // Reset values
    localparam logic [15:0] RST_MODE_ONE = 16'h0000;
    localparam logic [15:0] RST_MODE_TWO = 16'h0000;
    localparam logic [15:0] RST_OUT_ADJ  = 16'h0000;

    // Bits of the output adjustment word that hold state (phase 15:9, skew 2:0)
    localparam logic [15:0] OUT_ADJ_MASK = 16'hFE07;

    // Frequency codes
    localparam logic [1:0] FREQ_8K     = 2'h0;
    localparam logic [1:0] FREQ_1544K  = 2'h1;
    localparam logic [1:0] FREQ_2048K  = 2'h2;
    localparam logic [1:0] FREQ_BUS_8M = 2'h3;

    // Failure detect modes
    localparam logic [1:0] FDM_AUTO     = 2'h0;
    localparam logic [1:0] FDM_EXTERNAL = 2'h1;

    // Step sizes in picoseconds
    localparam int PHASE_STEP_FINE_PS   = 15000;
    localparam int PHASE_STEP_COARSE_PS = 20000;
    localparam int SKEW_STEP_PS         = 3500;

    // Free-running frame period on the link clock
    localparam int FRAME_PERIOD_NS   = 125000;
    localparam int LINK_CLK_KHZ      = 8192;
    localparam int FRAME_LINK_CYCLES = FRAME_PERIOD_NS * LINK_CLK_KHZ / 1000000;

    typedef enum logic [1:0] {
        ROLE_SLAVE     = 2'h0,
        ROLE_PRIMARY   = 2'h1,
        ROLE_SECONDARY = 2'h2,
        ROLE_INVALID   = 2'h3
    } hcm_role_t;

    typedef enum logic [2:0] {
        SRC_BUS_REF_1 = 3'h0,
        SRC_BUS_REF_2 = 3'h1,
        SRC_LOCAL_0   = 3'h2,
        SRC_LOCAL_1   = 3'h3,
        SRC_LOCAL_2   = 3'h4,
        SRC_LOCAL_3   = 3'h5,
        SRC_BUS_CLOCK = 3'h6,
        SRC_NONE      = 3'h7
    } hcm_src_t;

    typedef struct packed {
        logic       unused_15;
        logic       drive_b_group;
        logic       drive_a_group;
        logic       preferred_ref_select;
        logic [1:0] secondary_freq_code;
        logic [1:0] primary_freq_code;
        logic [3:0] secondary_source_sel;
        logic [3:0] primary_source_sel;
    } hcm_mode_one_t;

    typedef struct packed {
        logic [4:0] upper;
        logic       tie_correction_reset;
        logic [1:0] failure_detect_mode;
        logic [7:0] lower;
    } hcm_mode_two_t;

    typedef struct packed {
        logic [6:0] phase_offset;
        logic [5:0] unused;
        logic [2:0] output_skew;
    } hcm_out_adj_t;

endpackage

// >>> tb_top.sv
// Self-checking bench for the clock mode block over classic Wishbone.
// Assumes hcm_clock_mode, its checker and the backplane peer model.
`timescale 1ns/100ps
module tb_top;
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, link_clk_i = 0;
    logic dpll_on_secondary_i = 0, monitor_pri_fail_i = 0, monitor_sec_fail_i = 0;
    logic primary_loss_input_i = 0, secondary_loss_input_i = 0;
    logic [7:0]  adr_i = 8'h00;
    logic [3:0]  sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o, q;
    logic ack_o, a_group_oe_o, b_group_oe_o, prefer_secondary_o, tie_reset_o, frame_o;
    logic external_detect_o, primary_fail_o, secondary_fail_o, a_group_frame_i, b_group_frame_i;
    logic [1:0]  primary_freq_o, secondary_freq_o;
    logic signed [23:0] phase_offset_ps_o;
    logic [15:0] output_skew_ps_o;
    hcm_pkg::hcm_role_t role_o;
    hcm_pkg::hcm_src_t  primary_ref_o, secondary_ref_o;
    int miscompares = 0, comparisons = 0, cycles = 0;
    logic [3:0] srcs [6] = '{4'h0, 4'h1, 4'h8, 4'h9, 4'hA, 4'hB};
    initial forever #2.5 clk_i = ~clk_i;
    initial begin
        #7;
        forever #15 link_clk_i = ~link_clk_i;
    end
    hcm_clock_mode hcm_clock_mode_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .dpll_on_secondary_i(dpll_on_secondary_i), .monitor_pri_fail_i(monitor_pri_fail_i),
        .monitor_sec_fail_i(monitor_sec_fail_i), .primary_loss_input_i(primary_loss_input_i),
        .secondary_loss_input_i(secondary_loss_input_i), .role_o(role_o),
        .a_group_oe_o(a_group_oe_o), .b_group_oe_o(b_group_oe_o),
        .prefer_secondary_o(prefer_secondary_o), .primary_freq_o(primary_freq_o),
        .secondary_freq_o(secondary_freq_o), .primary_ref_o(primary_ref_o),
        .secondary_ref_o(secondary_ref_o), .tie_reset_o(tie_reset_o),
        .external_detect_o(external_detect_o), .primary_fail_o(primary_fail_o),
        .secondary_fail_o(secondary_fail_o), .phase_offset_ps_o(phase_offset_ps_o),
        .output_skew_ps_o(output_skew_ps_o), .link_clk_i(link_clk_i),
        .a_group_frame_i(a_group_frame_i), .b_group_frame_i(b_group_frame_i), .frame_o(frame_o));
    hcm_bus_peer hcm_bus_peer_i (.link_clk_i(link_clk_i), .rst_i(rst_i),
        .a_frame_o(a_group_frame_i), .b_frame_o(b_group_frame_i));
    task automatic wrap_up;
        $display("miscompares=%0d comparisons=%0d", miscompares, comparisons);
        if (miscompares == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; sel_i <= 4'h3; dat_i <= {16'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        if (n >= 50) chk({31'h0, ack_o}, 32'h1);
        q = dat_o;
        cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
    endtask
    task automatic settle;
        repeat (5) @(posedge clk_i);
        #1;
    endtask
    task automatic frame_chk(input logic use_b, input logic exp);
        int n;
        logic seen;
        n = 0;
        seen = 0;
        while ((use_b ? b_group_frame_i : a_group_frame_i) !== 1'b1 && n < 2100) begin
            @(posedge link_clk_i);
            n++;
        end
        if (n >= 2100) chk(n, 32'h0);
        repeat (6) begin
            @(posedge link_clk_i);
            #1;
            if (frame_o === 1'b1) seen = 1;
        end
        chk({31'h0, seen}, {31'h0, exp});
    endtask
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, cycles, 0);
            miscompares++;
            wrap_up();
        end
    end
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(0, 8'hAC, 16'h0); chk(q, 32'h0);
        wb(0, 8'hB0, 16'h0); chk(q, 32'h0);
        wb(0, 8'hB4, 16'h0); chk(q, 32'h0);
        wb(1, 8'h00, 16'hFFFF); wb(0, 8'h00, 16'h0); chk(q, 32'h0);
        settle; chk({role_o, a_group_oe_o, b_group_oe_o, primary_freq_o, secondary_freq_o,
            primary_ref_o, secondary_ref_o, tie_reset_o}, 32'h07ED);
        wb(1, 8'hB4, 16'hFFFF); wb(0, 8'hB4, 16'h0); chk(q, 32'hFE07);
        settle; chk(output_skew_ps_o, 32'h5FB4);
        chk({8'h0, phase_offset_ps_o}, 32'h00FFC568);
        wb(1, 8'hAC, 16'h2100); settle; chk({8'h0, phase_offset_ps_o}, 32'h00FFB1E0);
        chk({role_o, a_group_oe_o, b_group_oe_o}, 32'h6);
        wb(1, 8'hB4, 16'h8005); settle; chk({8'h0, phase_offset_ps_o}, 32'h00EC7800);
        chk(output_skew_ps_o, 32'h445C);
        for (int i = 0; i < 6; i++) begin
            wb(1, 8'hAC, {8'h20, srcs[i], srcs[i]}); settle;
            chk({primary_ref_o, secondary_ref_o}, {26'h0, i[2:0], i[2:0]});
        end
        for (int f = 0; f < 4; f++) begin
            wb(1, 8'hAC, {4'h2, f[1:0], f[1:0], 8'h88}); settle;
            chk({primary_freq_o, secondary_freq_o, primary_ref_o, secondary_ref_o},
                {22'h0, f[1:0], f[1:0], (f == 3) ? 6'h36 : 6'h12});
        end
        wb(1, 8'hAC, 16'h3000); settle; chk(prefer_secondary_o, 32'h0);
        wb(1, 8'hB0, 16'h0400); settle; chk(tie_reset_o, 32'h1);
        wb(1, 8'hB0, 16'h0100); settle; chk({tie_reset_o, external_detect_o}, 32'h0);
        wb(1, 8'hAC, 16'h4008); settle; chk({role_o, a_group_oe_o, b_group_oe_o,
            primary_freq_o, primary_ref_o}, 32'h13E);
        chk(external_detect_o, 32'h1);
        // Bench picks the active reference itself
        @(posedge clk_i);
        dpll_on_secondary_i <= 1'b0;
        primary_loss_input_i <= 1'b1;
        secondary_loss_input_i <= 1'b1;
        settle;
        chk({primary_fail_o, secondary_fail_o}, 32'h3);
        @(posedge clk_i);
        monitor_pri_fail_i <= 1'b1;
        monitor_sec_fail_i <= 1'b1;
        primary_loss_input_i <= 1'b0;
        secondary_loss_input_i <= 1'b0;
        settle;
        chk({primary_fail_o, secondary_fail_o}, 32'h0);
        wb(1, 8'hB0, 16'h0000); settle;
        chk({primary_fail_o, secondary_fail_o}, 32'h3);
        @(posedge clk_i);
        monitor_pri_fail_i <= 1'b0;
        monitor_sec_fail_i <= 1'b0;
        wb(1, 8'hAC, 16'h0000); dpll_on_secondary_i <= 1'b0;
        frame_chk(0, 1);
        frame_chk(1, 0);
        wb(0, 8'hC0, 16'h0); chk(q[6], 32'h1);
        dpll_on_secondary_i <= 1'b1;
        frame_chk(1, 1);
        frame_chk(0, 0);
        wrap_up();
    end
endmodule
bind hcm_clock_mode hcm_clock_mode_props props_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .role_o(role_o), .a_group_oe_o(a_group_oe_o),
    .b_group_oe_o(b_group_oe_o), .prefer_secondary_o(prefer_secondary_o),
    .primary_freq_o(primary_freq_o), .secondary_freq_o(secondary_freq_o),
    .primary_ref_o(primary_ref_o), .secondary_ref_o(secondary_ref_o), .tie_reset_o(tie_reset_o),
    .external_detect_o(external_detect_o), .primary_fail_o(primary_fail_o),
    .primary_loss_input_i(primary_loss_input_i), .output_skew_ps_o(output_skew_ps_o));
